// ---- include/irqm_pkg.sv ----
// constants and carrier types of the interrupt mask and manage block
package irqm_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] IRQM_ADDR_STATUS = 7'h01; // status read back
    localparam logic [6:0] IRQM_ADDR_EN_PRI = 7'h02; // irq_enable_primary
    localparam logic [6:0] IRQM_ADDR_EN_SEC = 7'h03; // irq_enable_secondary
    localparam logic [6:0] IRQM_ADDR_MGMT = 7'h04; // irq_management
    localparam logic [6:0] IRQM_ADDR_BEAT_IVL = 7'h25; // beat_interval_reg

    // ------------------------------------------------------------------
    // reset values and writable bit masks
    // ------------------------------------------------------------------
    localparam logic [23:0] IRQM_EN_RESET = 24'h000003;
    localparam logic [23:0] IRQM_EN_WMASK = 24'hff8f03;
    localparam logic [23:0] IRQM_MGMT_RESET = 24'h7b0004;
    localparam logic [23:0] IRQM_MGMT_WMASK = 24'hff0077;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int IRQM_EN_LSB = 8; // enables sit in bits 23:8
    localparam int IRQM_TYPE_LSB = 0; // pin_driver_type
    localparam int IRQM_CFT_LSB = 19; // cardio_fifo_threshold
    localparam int IRQM_IFT_LSB = 16; // impedance_fifo_threshold
    localparam int IRQM_REC_CLR_BIT = 6; // recovery_clear_mode
    localparam int IRQM_CLR_BEAT_LSB = 4; // beat_clear_mode
    localparam int IRQM_CLR_SYNC_BIT = 2; // sync_clear_mode
    localparam int IRQM_SYNC_RATE_LSB = 0; // sync_tick_rate

    // status vector index (status bit minus 8)
    localparam int IRQM_ST_CARDIO = 15;
    localparam int IRQM_ST_RECOV = 13;
    localparam int IRQM_ST_IMPED = 11;
    localparam int IRQM_ST_BEAT = 2;
    localparam int IRQM_ST_SYNC = 1;
    // latched-until-status-read bits of the status vector
    localparam logic [15:0] IRQM_LATCH_MASK = 16'h5789;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IRQM_DRV_HIZ = 2'b00,
        IRQM_DRV_PUSH = 2'b01,
        IRQM_DRV_OD = 2'b10,
        IRQM_DRV_OD_PULL = 2'b11
    } irqm_drv_e;

    typedef enum logic [1:0] {
        IRQM_BEAT_ON_STATUS = 2'b00,
        IRQM_BEAT_ON_IVL = 2'b01,
        IRQM_BEAT_SELF = 2'b10,
        IRQM_BEAT_RSVD = 2'b11
    } irqm_beat_e;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr; // write completes this cycle
        logic rd; // read completes this cycle
        logic [6:0] addr;
        logic [23:0] wdata;
    } irqm_req_s;

    typedef struct packed {
        logic [5:0] cardio_count; // unread cardio records, 0..32
        logic [3:0] imped_count; // unread impedance records, 0..8
        logic recovery_active; // quick recovery engaged
        logic beat_event; // new beat found, one cycle
        logic sample_tick; // cardio sample instant, one cycle
        logic rate_tick; // end of a cardio data-rate cycle
        logic quarter_tick; // quarter of a data-rate cycle passed
        logic [15:0] latch_cond; // raw conditions of latched bits
    } irqm_events_s;

endpackage : irqm_pkg

// ---- verilog/irqm_flag.sv ----
// one sticky status flag: set wins over clear
`timescale 1ns/10ps
module irqm_flag
    import irqm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic set,
    input wire logic clr,
    // flag
    output logic flag_q
);

    typedef struct packed {
        logic flag;
    } irqm_flag_s;

    irqm_flag_s q_r; // registered state
    irqm_flag_s q_nxt; // next state

    // next state: condition holds it, status read drops it
    always_comb begin
        q_nxt = q_r;
        q_nxt.flag = set | (q_r.flag & ~clr);
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign flag_q = q_r.flag;

    property p_set_wins;
        @(posedge clk) disable iff (rst) set |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("flag lost its set");

    property p_held;
        @(posedge clk) disable iff (rst)
            (flag_q && !clr) |=> flag_q;
    endproperty
    a_held: assert property (p_held)
        else $error("flag dropped without status read");

endmodule : irqm_flag

// ---- verilog/irqm_pin.sv ----
// active-low interrupt pin with selectable driver type
`timescale 1ns/10ps
module irqm_pin
    import irqm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request and configuration
    input wire logic active,
    input wire logic [1:0] drv_type,
    // pin
    output logic pin_out,
    output logic pin_oe_n,
    output logic pull_up_en
);

    typedef struct packed {
        logic o;
        logic oe_n;
        logic pull;
    } irqm_pin_s;

    irqm_pin_s q_r; // registered pin state
    irqm_pin_s q_nxt; // next pin state

    // driver select; low level always means service needed
    always_comb begin
        q_nxt = q_r;
        q_nxt.o = 1'b0;
        q_nxt.oe_n = 1'b1;
        q_nxt.pull = 1'b0;
        unique case (irqm_drv_e'(drv_type))
            IRQM_DRV_HIZ: begin
                q_nxt.oe_n = 1'b1;
            end
            IRQM_DRV_PUSH: begin
                q_nxt.oe_n = 1'b0;
                q_nxt.o = ~active;
            end
            IRQM_DRV_OD: begin
                q_nxt.oe_n = ~active;
            end
            IRQM_DRV_OD_PULL: begin
                q_nxt.oe_n = ~active;
                q_nxt.pull = 1'b1;
            end
        endcase
    end

    // state register; reset matches open drain with pull-up, idle
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '{o: 1'b0, oe_n: 1'b1, pull: 1'b1};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign pin_out = q_r.o;
    assign pin_oe_n = q_r.oe_n;
    assign pull_up_en = q_r.pull;

    property p_od_low;
        @(posedge clk) disable iff (rst)
            (active && drv_type == IRQM_DRV_OD) |=> (!pin_oe_n && !pin_out);
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open drain pin not pulled low");

    property p_hiz;
        @(posedge clk) disable iff (rst)
            (drv_type == IRQM_DRV_HIZ) |=> (pin_oe_n && !pull_up_en);
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("disabled pin is driven");

endmodule : irqm_pin

// ---- verilog/irqm_top.sv ----
// interrupt masking, pin drive and interrupt management registers
`timescale 1ns/10ps
module irqm_top
    import irqm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access, one completed serial transaction per pulse
    input wire irqm_req_s req,
    output logic [23:0] reg_rdata,
    // status conditions from the front end
    input wire irqm_events_s ev,
    // primary interrupt pin
    output logic irq_pin_primary_out,
    output logic irq_pin_primary_oe_n,
    output logic irq_pin_primary_pull,
    // secondary interrupt pin
    output logic irq_pin_secondary_out,
    output logic irq_pin_secondary_oe_n,
    output logic irq_pin_secondary_pull
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0] en_pri; // irq_enable_primary
        logic [23:0] en_sec; // irq_enable_secondary
        logic [23:0] mgmt; // irq_management
        logic [23:0] rdata; // read answer
        logic cardio; // cardio_fifo_irq
        logic imped; // impedance_fifo_irq
        logic rec; // quick_recovery_irq
        logic rec_prev; // recovery level one cycle ago
        logic beat; // beat_event_irq
        logic sync; // sync_tick_pulse
        logic [3:0] sync_cnt; // sample instants seen
    } irqm_top_s;

    irqm_top_s q_r; // registered state
    irqm_top_s q_nxt; // next state

    logic [15:0] latch_q; // latched status bits
    logic [15:0] st_vec; // status bits 23:8
    logic any_pri; // primary OR term
    logic any_sec; // secondary OR term
    logic stat_rd; // status read completes
    logic ivl_rd; // beat interval read completes

    // ------------------------------------------------------------------
    // decoded fields
    // ------------------------------------------------------------------
    logic [4:0] cft; // cardio threshold field
    logic [2:0] ift; // impedance threshold field
    logic [5:0] cardio_need; // records that raise cardio irq
    logic [3:0] imped_need; // records that raise impedance irq
    logic recovery_clear_mode; // recovery irq clear policy
    irqm_beat_e beat_mode; // beat_clear_mode
    logic clr_sync; // sync_clear_mode
    logic [1:0] sync_rate; // sync_tick_rate
    logic [3:0] rate_mask; // sample counter bits that must be zero

    assign cft = q_r.mgmt[IRQM_CFT_LSB +: 5];
    assign ift = q_r.mgmt[IRQM_IFT_LSB +: 3];
    assign cardio_need = {1'b0, cft} + 6'h01;
    assign imped_need = {1'b0, ift} + 4'h1;
    assign recovery_clear_mode = q_r.mgmt[IRQM_REC_CLR_BIT];
    assign beat_mode = irqm_beat_e'(q_r.mgmt[IRQM_CLR_BEAT_LSB +: 2]);
    assign clr_sync = q_r.mgmt[IRQM_CLR_SYNC_BIT];
    assign sync_rate = q_r.mgmt[IRQM_SYNC_RATE_LSB +: 2];

    // sample divider per sync rate code
    always_comb begin
        rate_mask = 4'h0;
        unique case (sync_rate)
            2'b00: rate_mask = 4'h0;
            2'b01: rate_mask = 4'h1;
            2'b10: rate_mask = 4'h3;
            2'b11: rate_mask = 4'hf;
        endcase
    end

    // read completions that clear status bits
    assign stat_rd = req.rd && (req.addr == IRQM_ADDR_STATUS);
    assign ivl_rd = req.rd && (req.addr == IRQM_ADDR_BEAT_IVL);

    // ------------------------------------------------------------------
    // latched status bits, one sticky cell per latched position
    // ------------------------------------------------------------------
    generate
        for (genvar i = 0; i < 16; i++) begin : g_latch
            if (IRQM_LATCH_MASK[i]) begin : g_cell
                irqm_flag u_flag (
                    .clk(clk),
                    .rst(rst),
                    .set(ev.latch_cond[i]),
                    .clr(stat_rd),
                    .flag_q(latch_q[i])
                );
            end else begin : g_none
                assign latch_q[i] = 1'b0;
            end
        end
    endgenerate

    // status vector: managed bits over the latched ones
    always_comb begin
        st_vec = latch_q;
        st_vec[IRQM_ST_CARDIO] = q_r.cardio;
        st_vec[IRQM_ST_RECOV] = q_r.rec;
        st_vec[IRQM_ST_IMPED] = q_r.imped;
        st_vec[IRQM_ST_BEAT] = q_r.beat;
        st_vec[IRQM_ST_SYNC] = q_r.sync;
    end

    // per-pin OR terms over enabled status bits
    assign any_pri = |(st_vec & q_r.en_pri[IRQM_EN_LSB +: 16]);
    assign any_sec = |(st_vec & q_r.en_sec[IRQM_EN_LSB +: 16]);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic rise; // recovery just entered
        logic fire; // sync pulse issued this sample
        logic beat_clr; // beat clear event for the chosen mode
        logic sync_clr; // sync clear event for the chosen mode
        rise = 1'b0;
        fire = 1'b0;
        beat_clr = 1'b0;
        sync_clr = 1'b0;
        q_nxt = q_r;

        // register writes; reserved bits stay zero
        if (req.wr) begin
            unique case (req.addr)
                IRQM_ADDR_EN_PRI: begin
                    q_nxt.en_pri = req.wdata & IRQM_EN_WMASK;
                end
                IRQM_ADDR_EN_SEC: begin
                    q_nxt.en_sec = req.wdata & IRQM_EN_WMASK;
                end
                IRQM_ADDR_MGMT: begin
                    q_nxt.mgmt = req.wdata & IRQM_MGMT_WMASK;
                end
                default: begin
                    // other addresses belong to other blocks
                end
            endcase
        end

        // read answer; other addresses answer zero
        if (req.rd) begin
            unique case (req.addr)
                IRQM_ADDR_STATUS: q_nxt.rdata = {st_vec, 8'h00};
                IRQM_ADDR_EN_PRI: q_nxt.rdata = q_r.en_pri;
                IRQM_ADDR_EN_SEC: q_nxt.rdata = q_r.en_sec;
                IRQM_ADDR_MGMT: q_nxt.rdata = q_r.mgmt;
                default: q_nxt.rdata = 24'h000000;
            endcase
        end

        // fifo fill thresholds
        q_nxt.cardio = ev.cardio_count >= cardio_need;
        q_nxt.imped = ev.imped_count >= imped_need;

        // quick recovery irq
        q_nxt.rec_prev = ev.recovery_active;
        rise = ev.recovery_active & ~q_r.rec_prev;
        if (recovery_clear_mode) begin
            // one shot per entry, a read drops it
            q_nxt.rec = rise | (q_r.rec & ~stat_rd);
        end else begin
            // follows the mode, held until a read
            q_nxt.rec = ev.recovery_active | (q_r.rec & ~stat_rd);
        end

        // beat irq; reserved code acts as status read clear
        unique case (beat_mode)
            IRQM_BEAT_ON_STATUS: beat_clr = stat_rd;
            IRQM_BEAT_ON_IVL: beat_clr = ivl_rd;
            IRQM_BEAT_SELF: beat_clr = ev.rate_tick;
            IRQM_BEAT_RSVD: beat_clr = stat_rd;
        endcase
        q_nxt.beat = ev.beat_event | (q_r.beat & ~beat_clr);

        // sync pulse divider and clear
        if (ev.sample_tick) begin
            q_nxt.sync_cnt = q_r.sync_cnt + 4'h1;
            fire = (q_r.sync_cnt & rate_mask) == 4'h0;
        end
        sync_clr = clr_sync ? ev.quarter_tick : stat_rd;
        q_nxt.sync = fire | (q_r.sync & ~sync_clr);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q_r <= '0;
            q_r.en_pri <= IRQM_EN_RESET;
            q_r.en_sec <= IRQM_EN_RESET;
            q_r.mgmt <= IRQM_MGMT_RESET;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign reg_rdata = q_r.rdata;

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    irqm_pin u_pin_pri (
        .clk(clk),
        .rst(rst),
        .active(any_pri),
        .drv_type(q_r.en_pri[IRQM_TYPE_LSB +: 2]),
        .pin_out(irq_pin_primary_out),
        .pin_oe_n(irq_pin_primary_oe_n),
        .pull_up_en(irq_pin_primary_pull)
    );

    irqm_pin u_pin_sec (
        .clk(clk),
        .rst(rst),
        .active(any_sec),
        .drv_type(q_r.en_sec[IRQM_TYPE_LSB +: 2]),
        .pin_out(irq_pin_secondary_out),
        .pin_oe_n(irq_pin_secondary_oe_n),
        .pull_up_en(irq_pin_secondary_pull)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_reset_vals;
        @(posedge clk) rst |=> (q_r.en_pri == 24'h000003 &&
            q_r.en_sec == 24'h000003 && q_r.mgmt == 24'h7b0004);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_masked_pin;
        @(posedge clk) disable iff (rst)
            (st_vec != 16'h0000 && q_r.en_pri[23:8] == 16'h0000) |=>
                (irq_pin_primary_oe_n || irq_pin_primary_out);
    endproperty
    a_masked_pin: assert property (p_masked_pin)
        else $error("masked status drove primary pin");

    property p_sec_pin;
        @(posedge clk) disable iff (rst)
            (any_sec && q_r.en_sec[1:0] == 2'b01) |=>
                (!irq_pin_secondary_out && !irq_pin_secondary_oe_n);
    endproperty
    a_sec_pin: assert property (p_sec_pin)
        else $error("secondary pin not low");

    property p_cardio;
        @(posedge clk) disable iff (rst)
            (!req.wr && ev.cardio_count == {1'b0, cft} + 6'h01) |=>
                q_r.cardio ##1 ($past(ev.cardio_count) != 6'h00 ||
                !q_r.cardio);
    endproperty
    a_cardio: assert property (p_cardio)
        else $error("cardio fifo irq missed its threshold");

    property p_imped;
        @(posedge clk) disable iff (rst)
            (ev.imped_count < {1'b0, ift} + 4'h1) |=> !q_r.imped;
    endproperty
    a_imped: assert property (p_imped)
        else $error("impedance fifo irq early");

    property p_rec_hold;
        @(posedge clk) disable iff (rst)
            (!recovery_clear_mode && ev.recovery_active) |=> q_r.rec;
    endproperty
    a_rec_hold: assert property (p_rec_hold)
        else $error("recovery irq dropped while engaged");

    property p_rec_once;
        @(posedge clk) disable iff (rst)
            (recovery_clear_mode && stat_rd && q_r.rec_prev &&
                ev.recovery_active) |=> !q_r.rec;
    endproperty
    a_rec_once: assert property (p_rec_once)
        else $error("recovery irq not cleared by read");

    property p_beat_self;
        @(posedge clk) disable iff (rst)
            (beat_mode == IRQM_BEAT_SELF && ev.rate_tick && !ev.beat_event)
                |=> !q_r.beat;
    endproperty
    a_beat_self: assert property (p_beat_self)
        else $error("beat irq did not self clear");

    property p_sync_every;
        @(posedge clk) disable iff (rst)
            (ev.sample_tick && sync_rate == 2'b00) |=> q_r.sync;
    endproperty
    a_sync_every: assert property (p_sync_every)
        else $error("sync pulse missing");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
            (req.rd && req.addr == IRQM_ADDR_EN_PRI) |=>
                (reg_rdata & 24'h0070fc) == 24'h000000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved enable bits read nonzero");

endmodule : irqm_top

// ---- tb/irqm_host.sv ----
// host side model: the interrupt wire as the host sees it
`timescale 1ns/10ps
module irqm_host
    import irqm_pkg::*;
(
    // clock
    input wire logic clk,
    // pin as the device drives it
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic pin_pull,
    // wire level and service request
    output logic level,
    output logic service
);
    logic float_r = 1'b0; // floating wire never holds a level
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end
    // driver first, then pull-up, else a changing level
    always_comb begin
        if (!pin_oe_n) level = pin_out;
        else if (pin_pull) level = 1'b1;
        else level = float_r;
    end
    assign service = ~level; // low wire asks for service
endmodule : irqm_host

// ---- tb/testbench.sv ----
// self-checking bench of the interrupt mask and manage block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end
module testbench import irqm_pkg::*;;
    typedef struct packed {
        logic [4:0] cft; // cardio threshold field
        logic [2:0] ift; // impedance threshold field
        logic [5:0] cc; // cardio records
        logic [3:0] ic; // impedance records
        logic ep; // primary pin low expected
        logic es; // secondary pin low expected
    } irqm_row_s;
    localparam logic [30:0] M_LC0 = 31'h00000001;
    localparam logic [30:0] M_Q = 31'h00010000;
    localparam logic [30:0] M_RATE = 31'h00020000;
    localparam logic [30:0] M_SAMPLE = 31'h00040000;
    localparam logic [30:0] M_BEAT = 31'h00080000;
    logic clk;
    logic rst;
    irqm_req_s req;
    irqm_events_s ev;
    logic [23:0] reg_rdata;
    logic [23:0] d; // last read answer
    logic p_out, p_oe_n, p_pull, p_lvl;
    logic s_out, s_oe_n, s_pull, s_lvl;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    int bad;
    irqm_row_s rows [6] = '{
        '{5'd0, 3'd0, 6'd1, 4'd0, 1'b1, 1'b0},
        '{5'd0, 3'd0, 6'd0, 4'd1, 1'b0, 1'b1},
        '{5'd15, 3'd3, 6'd15, 4'd4, 1'b0, 1'b1},
        '{5'd15, 3'd3, 6'd16, 4'd3, 1'b1, 1'b0},
        '{5'd31, 3'd7, 6'd31, 4'd7, 1'b0, 1'b0},
        '{5'd31, 3'd7, 6'd32, 4'd8, 1'b1, 1'b1}};
    // ------------------------------------------------------------
    // clock, design and host wires
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    irqm_top uut (.clk(clk), .rst(rst), .req(req), .reg_rdata(reg_rdata),
        .ev(ev), .irq_pin_primary_out(p_out),
        .irq_pin_primary_oe_n(p_oe_n), .irq_pin_primary_pull(p_pull),
        .irq_pin_secondary_out(s_out), .irq_pin_secondary_oe_n(s_oe_n),
        .irq_pin_secondary_pull(s_pull));
    irqm_host host_p (.clk(clk), .pin_out(p_out), .pin_oe_n(p_oe_n),
        .pin_pull(p_pull), .level(p_lvl), .service());
    irqm_host host_s (.clk(clk), .pin_out(s_out), .pin_oe_n(s_oe_n),
        .pin_pull(s_pull), .level(s_lvl), .service());
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick
    // one completed register write
    task automatic wr(input logic [6:0] a, input logic [23:0] v);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    // one completed register read, answer into d
    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 24'h000000};
        @(posedge clk);
        req.rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask : rd
    // one-cycle pulse on the event lines
    task automatic pulse(input logic [30:0] m);
        @(posedge clk);
        ev <= irqm_events_s'(ev | m);
        @(posedge clk);
        ev <= irqm_events_s'(ev & ~m);
    endtask : pulse
    // status read, one bit compared
    task automatic chk_st(input int b, input logic e);
        rd(IRQM_ADDR_STATUS);
        `CHK("status bit", e, d[b])
    endtask : chk_st
    task automatic wrap_up;
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        req = '0;
        ev = '0;
        tick(10);
        rst <= 1'b0;
        rd(IRQM_ADDR_EN_PRI);
        `CHK("en_pri", 24'h000003, d)
        `CHK("pri idle", 1'b1, p_lvl)
        rd(IRQM_ADDR_MGMT);
        `CHK("mgmt", 24'h7b0004, d)
        wr(IRQM_ADDR_EN_SEC, 24'hffffff);
        rd(IRQM_ADDR_EN_SEC);
        `CHK("en_sec", 24'hff8f03, d)
        wr(IRQM_ADDR_MGMT, 24'hffffdf); // beat code 11 never written
        rd(IRQM_ADDR_MGMT);
        `CHK("mgmt", 24'hff0057, d)
        rd(7'h05);
        `CHK("unmapped", 24'h000000, d)
        // fifo thresholds, one fifo per pin
        wr(IRQM_ADDR_EN_PRI, 24'h800001);
        wr(IRQM_ADDR_EN_SEC, 24'h080001);
        foreach (rows[i]) begin
            wr(IRQM_ADDR_MGMT, {rows[i].cft, rows[i].ift, 16'h0004});
            ev.cardio_count <= rows[i].cc;
            ev.imped_count <= rows[i].ic;
            tick(3);
            `CHK("pri", ~rows[i].ep, p_lvl)
            `CHK("sec", ~rows[i].es, s_lvl)
        end
        wr(IRQM_ADDR_EN_PRI, 24'h000001); // host masks a standing irq
        tick(2);
        `CHK("masked", 1'b1, p_lvl)
        ev.cardio_count <= 6'd0;
        ev.imped_count <= 4'd0;
        // driver types on a latched bit
        for (int t = 0; t < 4; t++) begin
            wr(IRQM_ADDR_EN_PRI, 24'h000100 | 24'(t));
            pulse(M_LC0);
            tick(2);
            `CHK("oe_n", t == 0, p_oe_n)
            if (t != 0) `CHK("lvl", 1'b0, p_lvl)
            `CHK("pull", t == 3, p_pull)
        end
        chk_st(8, 1'b1);
        tick(1);
        `CHK("released", 1'b1, p_oe_n)
        // recovery irq, both clear modes
        wr(IRQM_ADDR_MGMT, 24'h7b0004);
        ev.recovery_active <= 1'b1;
        tick(2);
        chk_st(21, 1'b1);
        chk_st(21, 1'b1);
        ev.recovery_active <= 1'b0;
        tick(2);
        chk_st(21, 1'b1);
        chk_st(21, 1'b0);
        wr(IRQM_ADDR_MGMT, 24'h7b0044);
        ev.recovery_active <= 1'b1;
        tick(2);
        chk_st(21, 1'b1);
        chk_st(21, 1'b0);
        ev.recovery_active <= 1'b0;
        tick(2);
        ev.recovery_active <= 1'b1;
        tick(2);
        chk_st(21, 1'b1);
        ev.recovery_active <= 1'b0;
        // beat clear modes 00, 01, 10
        for (int m = 0; m < 3; m++) begin
            wr(IRQM_ADDR_MGMT, 24'h7b0004 | 24'(m << 4));
            pulse(M_BEAT);
            tick(1);
            chk_st(10, 1'b1);
            if (m > 0) chk_st(10, 1'b1);
            if (m == 1) rd(IRQM_ADDR_BEAT_IVL);
            if (m == 2) pulse(M_RATE);
            chk_st(10, 1'b0);
        end
        // sync pulse rates on the dedicated pin
        wr(IRQM_ADDR_EN_SEC, 24'h000201);
        for (int r = 0; r < 4; r++) begin
            wr(IRQM_ADDR_MGMT, 24'h7b0004 | 24'(r));
            n = 0;
            bad = 0;
            repeat (16) begin
                pulse(M_SAMPLE);
                tick(2);
                n += (s_lvl === 1'b0);
                pulse(M_Q);
                tick(2);
                bad += (s_lvl !== 1'b1);
            end
            `CHK("sync count", (r == 3) ? 1 : 16 >> r, n)
            `CHK("sync self clear", 0, bad)
        end
        wr(IRQM_ADDR_MGMT, 24'h7b0000);
        pulse(M_SAMPLE);
        pulse(M_Q);
        tick(2);
        `CHK("sync held", 1'b0, s_lvl)
        chk_st(9, 1'b1);
        tick(1);
        `CHK("sync read clear", 1'b1, s_lvl)
        // second reset in mid-run
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        rd(IRQM_ADDR_EN_SEC);
        `CHK("en_sec", 24'h000003, d)
        `CHK("sec oe_n", 1'b1, s_oe_n)
        `CHK("sec pull", 1'b1, s_pull)
        wrap_up();
    end
endmodule : testbench
